// File: design/input_ov_fault_response.sv
/*
 * Input over-voltage warning response: command port for the response byte and
 * user store, the fault latch, its clearing paths and the retry sequencer.
 * Assumes warning, control and reset pins are asynchronous, the operation
 * command and unit tick come from logic on the core clock.
 */
`timescale 1ns/1ps
module input_ov_fault_response (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic cmd_write_in,
    input wire logic cmd_read_in,
    input wire logic [7:0] cmd_code_in,
    input wire logic [ovw_pkg::STORE_W-1:0] cmd_wdata_in,
    output logic [ovw_pkg::STORE_W-1:0] cmd_rdata_out,
    output logic cmd_ack_out,
    output logic cmd_nack_out,
    input wire logic clear_faults_in,
    input wire logic clear_warn_bit_in,
    input wire logic fault_reset_pin_in,
    input wire logic ctrl_pin_in,
    input wire logic operation_on_in,
    input wire logic vin_ov_warn_in,
    input wire logic unit_tick_in,
    output logic power_enable_out,
    output logic warn_latched_out,
    output logic [2:0] retry_count_out,
    output logic restarting_out
);
    import ovw_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        logic warn_s1;
        logic warn_s2;
        logic ctrl_s1;
        logic ctrl_s2;
        logic rst_s1;
        logic rst_s2;
        logic warn_prev;
        logic on_prev;
        logic [7:0] resp;
        resp_state_t state;
        logic [2:0] tries;
        logic latched;
        logic pwr_en;
        logic restarting;
        logic timer_start;
        logic [STORE_W-1:0] rdata;
        logic ack;
        logic nack;
    } core_t;

    core_t st;
    core_t next_st;

    logic [STORE_W-1:0] store_data;
    logic timer_done;
    logic store_write;
    logic on_cmd;
    logic on_rise;
    logic warn_rise;
    logic clr;
    action_t act;
    logic [2:0] retry_set;
    logic [2:0] delay_code;

    // ==========================================================
    // Decoded events
    assign act = action_t'(st.resp[ACT_HI:ACT_LO]);
    assign retry_set = st.resp[RETRY_HI:RETRY_LO];
    assign delay_code = st.resp[DELAY_HI:DELAY_LO];
    assign on_cmd = st.ctrl_s2 && operation_on_in;
    assign on_rise = on_cmd && !st.on_prev;
    assign warn_rise = st.warn_s2 && !st.warn_prev;
    assign clr = clear_warn_bit_in || clear_faults_in || st.rst_s2 || on_rise;
    assign store_write = cmd_write_in && (cmd_code_in == CODE_USER_STORE);

    // ==========================================================
    // Submodules
    ovw_user_store #(
        .WIDTH(STORE_W)
    ) u_store (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .write_in(store_write),
        .wdata_in(cmd_wdata_in),
        .data_out(store_data)
    );

    ovw_delay_timer #(
        .UNITS_W(UNITS_W)
    ) u_timer (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .start_in(st.timer_start),
        .units_in(delay_units(delay_code)),
        .tick_in(unit_tick_in),
        .done_out(timer_done)
    );

    // ==========================================================
    // Next state
    always_comb begin
        resp_state_t cur;
        logic [2:0] cur_tries;
        cur = st.state;
        cur_tries = st.tries;
        next_st = st;
        next_st.warn_s1 = vin_ov_warn_in;
        next_st.warn_s2 = st.warn_s1;
        next_st.ctrl_s1 = ctrl_pin_in;
        next_st.ctrl_s2 = st.ctrl_s1;
        next_st.rst_s1 = fault_reset_pin_in;
        next_st.rst_s2 = st.rst_s1;
        next_st.warn_prev = st.warn_s2;
        next_st.on_prev = on_cmd;
        next_st.timer_start = 1'b0;
        next_st.ack = 1'b0;
        next_st.nack = 1'b0;

        // Command port; a read returns the value held before any write in the same cycle.
        if (cmd_write_in || cmd_read_in) begin
            if (cmd_code_in == CODE_WARN_ACTION) begin
                next_st.ack = 1'b1;
                next_st.rdata = {{(STORE_W-8){1'b0}}, st.resp};
                if (cmd_write_in) begin
                    next_st.resp = cmd_wdata_in[7:0];
                end
            end else if (cmd_code_in == CODE_USER_STORE) begin
                next_st.ack = 1'b1;
                next_st.rdata = store_data;
            end else begin
                next_st.nack = 1'b1;
            end
        end

        // A new warning in the clearing cycle still latches.
        if (warn_rise) begin
            next_st.latched = 1'b1;
        end else if (clr) begin
            next_st.latched = 1'b0;
        end

        // Commanded off also ends an endless retry run.
        if (clr || !on_cmd) begin
            cur = ST_RUN;
            cur_tries = 3'h0;
        end
        next_st.state = cur;
        next_st.tries = cur_tries;

        if (on_cmd) begin
            case (cur)
                ST_RUN: begin
                    if (warn_rise) begin
                        case (act)
                            ACT_IGNORE: begin
                                next_st.state = ST_RUN;
                            end
                            ACT_DELAY: begin
                                next_st.state = ST_GRACE;
                                next_st.timer_start = 1'b1;
                            end
                            ACT_DISABLE_RETRY: begin
                                if (retry_set == RETRY_NONE) begin
                                    next_st.state = ST_LATCHED;
                                end else begin
                                    next_st.state = ST_RETRY_WAIT;
                                    next_st.timer_start = 1'b1;
                                end
                            end
                            default: begin
                                next_st.state = ST_LATCHED;
                            end
                        endcase
                    end
                end
                ST_GRACE: begin
                    if (timer_done) begin
                        if (!st.warn_s2) begin
                            next_st.state = ST_RUN;
                        end else if (retry_set == RETRY_NONE) begin
                            next_st.state = ST_LATCHED;
                        end else begin
                            next_st.state = ST_RETRY_WAIT;
                            next_st.timer_start = 1'b1;
                        end
                    end
                end
                ST_RETRY_WAIT: begin
                    if (timer_done) begin
                        next_st.state = ST_RETRY_TRY;
                        next_st.tries = cur_tries + 3'h1;
                        next_st.timer_start = 1'b1;
                    end
                end
                ST_RETRY_TRY: begin
                    if (timer_done) begin
                        if (!st.warn_s2) begin
                            next_st.state = ST_RUN;
                            next_st.tries = 3'h0;
                        end else if (retry_set != RETRY_FOREVER && cur_tries >= retry_set) begin
                            next_st.state = ST_LATCHED;
                        end else begin
                            next_st.timer_start = 1'b1;
                            if (cur_tries != RETRY_FOREVER) begin
                                next_st.tries = cur_tries + 3'h1;
                            end
                        end
                    end
                end
                ST_LATCHED: begin
                    next_st.state = ST_LATCHED;
                end
                default: begin
                    next_st.state = ST_RUN;
                end
            endcase
        end

        next_st.pwr_en = on_cmd && (next_st.state == ST_RUN || next_st.state == ST_GRACE
            || next_st.state == ST_RETRY_TRY);
        next_st.restarting = (next_st.state == ST_RETRY_WAIT || next_st.state == ST_RETRY_TRY);
    end

    // ==========================================================
    // Registers
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            st <= '0;
            st.resp <= WARN_ACTION_RESET;
            st.state <= ST_RUN;
        end else begin
            st <= next_st;
        end
    end

    assign cmd_rdata_out = st.rdata;
    assign cmd_ack_out = st.ack;
    assign cmd_nack_out = st.nack;
    assign power_enable_out = st.pwr_en;
    assign warn_latched_out = st.latched;
    assign retry_count_out = st.tries;
    assign restarting_out = st.restarting;

    // ==========================================================
    // Checks
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    sequence seq_store_write;
        cmd_write_in && cmd_code_in == CODE_USER_STORE;
    endsequence

    sequence seq_store_read;
        cmd_read_in && !cmd_write_in && cmd_code_in == CODE_USER_STORE;
    endsequence

    chk_store_readback: assert property (
        seq_store_write ##1 seq_store_read |=> cmd_ack_out && cmd_rdata_out == $past(cmd_wdata_in, 2))
        else $error("user store read back differs from written data");

    chk_action_readback: assert property (
        cmd_write_in && cmd_code_in == CODE_WARN_ACTION ##1 cmd_read_in && !cmd_write_in
        && cmd_code_in == CODE_WARN_ACTION |=> cmd_rdata_out[7:0] == $past(cmd_wdata_in[7:0], 2))
        else $error("response byte read back differs");

    chk_warn_latches: assert property (
        warn_rise |=> warn_latched_out)
        else $error("warning did not latch");

    chk_clear_drops: assert property (
        (clear_faults_in || clear_warn_bit_in) && !warn_rise |=> !warn_latched_out && retry_count_out == 3'h0)
        else $error("clear did not drop fault and attempts");

    chk_toggle_clears: assert property (
        on_rise && !warn_rise |=> !warn_latched_out)
        else $error("off then on did not clear fault");

    chk_ignore_runs: assert property (
        warn_rise && act == ACT_IGNORE && on_cmd && st.state == ST_RUN |=> power_enable_out)
        else $error("ignored warning disturbed output");

    chk_disable_fast: assert property (
        warn_rise && act == ACT_DISABLE_RETRY && on_cmd && !clr && st.state == ST_RUN
        |=> !power_enable_out ##1 !power_enable_out)
        else $error("output not disabled on warning");

    chk_latched_off: assert property (
        st.state == ST_LATCHED |-> !power_enable_out)
        else $error("output on while latched off");

    chk_no_retry: assert property (
        st.state == ST_RETRY_TRY |-> retry_set != RETRY_NONE)
        else $error("restart attempted with retries disabled");

    chk_try_limit: assert property (
        st.state == ST_RETRY_TRY && retry_set != RETRY_FOREVER |-> st.tries <= retry_set && st.tries != 3'h0)
        else $error("attempt count beyond setting");

    chk_fresh_count: assert property (
        clr |=> st.tries == 3'h0)
        else $error("attempt counter kept after clear");

endmodule : input_ov_fault_response

// File: design/ovw_pkg.sv
/*
 * Shared constants, state encoding and delay decode for the input
 * over-voltage warning response block.
 * Assumes one core clock and a command port driven by a PMBus front end.
 */
// Function
// - Response byte at 0xC4: action, retries, delay.
// - Action 00: keep regulating, no shutdown.
// - Action 01: run for delay, then retry.
// - Action 10: disable at once, then retry.
// - Action 11: stay off until fault cleared.
// - Clearing the status bit clears fault.
// - Clear-faults command or reset pin clears fault.
// - Off-then-on command clears the fault.
// - Retry 000: never restart, stay off.
// - Retry 1-4: try that often, then off.
// - Attempts start one delay interval apart.
// - 16-byte user store at 0xB0, read back.
// - Delay codes 1-7 mean 2 to 128 units.
// - Retry 5, 6 times; 111 retries forever.
package ovw_pkg;

    // ==========================================================
    // Command codes and field layout
    localparam logic [7:0] CODE_USER_STORE = 8'hb0;
    localparam logic [7:0] CODE_WARN_ACTION = 8'hc4;
    localparam int ACT_HI = 7;
    localparam int ACT_LO = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam int DELAY_HI = 2;
    localparam int DELAY_LO = 0;

    // ==========================================================
    // Reset values and special field codes
    localparam logic [7:0] WARN_ACTION_RESET = 8'h00;
    localparam logic [127:0] USER_STORE_RESET = 128'h0;
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;
    localparam int STORE_W = 128;
    localparam int UNITS_W = 8;

    typedef enum logic [1:0] {
        ACT_IGNORE,
        ACT_DELAY,
        ACT_DISABLE_RETRY,
        ACT_LATCH
    } action_t;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_GRACE,
        ST_RETRY_WAIT,
        ST_RETRY_TRY,
        ST_LATCHED
    } resp_state_t;

    // ==========================================================
    // Delay code to unit count; code 0 means no wait at all.
    function automatic logic [UNITS_W-1:0] delay_units(input logic [2:0] code);
        delay_units = (code == 3'h0) ? 8'h00 : (8'h01 << code);
    endfunction : delay_units

endpackage : ovw_pkg

// File: design/ovw_delay_timer.sv
/*
 * Interval timer counting delay-unit ticks after a start pulse.
 * Assumes the unit tick is a one-cycle pulse on the core clock.
 */
`timescale 1ns/1ps
module ovw_delay_timer #(
    parameter int UNITS_W = ovw_pkg::UNITS_W
) (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic start_in,
    input wire logic [UNITS_W-1:0] units_in,
    input wire logic tick_in,
    output logic done_out
);
    import ovw_pkg::*;

    typedef struct packed {
        logic busy;
        logic [UNITS_W-1:0] target;
        logic [UNITS_W-1:0] count;
        logic done;
    } timer_t;

    timer_t st;
    timer_t next_st;

    // ==========================================================
    // A restart aborts any interval in flight, so each attempt is timed from its own start.
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        if (start_in) begin
            next_st.target = units_in;
            next_st.count = '0;
            next_st.busy = (units_in != '0);
            next_st.done = (units_in == '0);
        end else if (st.busy && tick_in) begin
            next_st.count = st.count + 1'b1;
            if (st.count + 1'b1 == st.target) begin
                next_st.busy = 1'b0;
                next_st.done = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign done_out = st.done;

endmodule : ovw_delay_timer

// File: design/ovw_user_store.sv
/*
 * Sixteen-byte user data store written and read whole.
 * Assumes the caller decodes the command code into a write strobe.
 */
`timescale 1ns/1ps
module ovw_user_store #(
    parameter int WIDTH = ovw_pkg::STORE_W
) (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic write_in,
    input wire logic [WIDTH-1:0] wdata_in,
    output logic [WIDTH-1:0] data_out
);
    import ovw_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] bytes;
    } store_t;

    store_t st;
    store_t next_st;

    // ==========================================================
    always_comb begin
        next_st = st;
        if (write_in) begin
            next_st.bytes = wdata_in;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            st.bytes <= WIDTH'(USER_STORE_RESET);
        end else begin
            st <= next_st;
        end
    end

    assign data_out = st.bytes;

endmodule : ovw_user_store

// File: sim/pmbus_host_model.sv
/*
 * Host model for the response block: command accesses, clear requests and on/off controls.
 * Assumes a rising-edge core clock; every change is made at a falling edge.
 */
`timescale 1ns/1ps
module pmbus_host_model (
    input wire logic core_clk_in,
    input wire logic cmd_ack_in,
    input wire logic cmd_nack_in,
    input wire logic [ovw_pkg::STORE_W-1:0] cmd_rdata_in,
    output logic cmd_write_out,
    output logic cmd_read_out,
    output logic [7:0] cmd_code_out,
    output logic [ovw_pkg::STORE_W-1:0] cmd_wdata_out,
    output logic clear_faults_out,
    output logic clear_warn_bit_out,
    output logic fault_reset_pin_out,
    output logic ctrl_pin_out,
    output logic operation_on_out
);
    import ovw_pkg::*;

    initial begin
        cmd_write_out = 1'b0;
        cmd_read_out = 1'b0;
        cmd_code_out = 8'h00;
        cmd_wdata_out = '0;
        clear_faults_out = 1'b0;
        clear_warn_bit_out = 1'b0;
        fault_reset_pin_out = 1'b0;
        ctrl_pin_out = 1'b1;
        operation_on_out = 1'b1;
    end

    // ==========================================================
    // Command access
    // Released code and data lines show the inverse of their last value, so a stale capture cannot pass.
    task automatic access(input logic wr, input logic [7:0] code, input logic [STORE_W-1:0] wdata,
                          output logic [STORE_W-1:0] rdata, output logic ack, output logic nack);
        @(negedge core_clk_in);
        cmd_code_out = code;
        cmd_wdata_out = wdata;
        cmd_write_out = wr;
        cmd_read_out = ~wr;
        // The answer stands for one cycle only, so it is taken before the lines are released.
        @(negedge core_clk_in);
        rdata = cmd_rdata_in;
        ack = cmd_ack_in;
        nack = cmd_nack_in;
        cmd_write_out = 1'b0;
        cmd_read_out = 1'b0;
        cmd_code_out = ~code;
        cmd_wdata_out = ~wdata;
    endtask : access

    // Write and then read the same code in the very next cycle, with no idle cycle between.
    task automatic write_read(input logic [7:0] code, input logic [STORE_W-1:0] wdata,
                              output logic [STORE_W-1:0] rdata, output logic ack);
        @(negedge core_clk_in);
        cmd_code_out = code;
        cmd_wdata_out = wdata;
        cmd_write_out = 1'b1;
        @(negedge core_clk_in);
        cmd_write_out = 1'b0;
        cmd_read_out = 1'b1;
        @(negedge core_clk_in);
        rdata = cmd_rdata_in;
        ack = cmd_ack_in;
        cmd_read_out = 1'b0;
        cmd_code_out = ~code;
        cmd_wdata_out = ~wdata;
    endtask : write_read

    // ==========================================================
    // Fault clearing
    // Pins pass a two-stage synchroniser, so pin requests are held four cycles.
    task automatic clear_fault(input int kind);
        @(negedge core_clk_in);
        case (kind)
            0: clear_warn_bit_out = 1'b1;
            1: clear_faults_out = 1'b1;
            2: fault_reset_pin_out = 1'b1;
            3: ctrl_pin_out = 1'b0;
            4: operation_on_out = 1'b0;
            default: begin
                ctrl_pin_out = 1'b0;
                operation_on_out = 1'b0;
            end
        endcase
        repeat ((kind < 2) ? 1 : 4) @(negedge core_clk_in);
        clear_warn_bit_out = 1'b0;
        clear_faults_out = 1'b0;
        fault_reset_pin_out = 1'b0;
        ctrl_pin_out = 1'b1;
        operation_on_out = 1'b1;
    endtask : clear_fault

endmodule : pmbus_host_model

// File: sim/tb_input_ov_fault_response.sv
/*
 * Self-checking testbench for the input over-voltage warning response block.
 * Assumes the design package and the host model are compiled before it.
 */
`timescale 1ns/1ps
module tb_input_ov_fault_response;
    import ovw_pkg::*;

    logic core_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic vin_ov_warn = 1'b0;
    logic unit_tick = 1'b0;
    logic [1:0] tick_phase = 2'h0;
    logic cmd_write, cmd_read, cmd_ack, cmd_nack, clr_faults, clr_bit, rst_pin, ctrl_pin, op_on;
    logic power, latched, restarting, ack, nack;
    logic [7:0] cmd_code;
    logic [2:0] tries;
    logic [STORE_W-1:0] cmd_wdata, cmd_rdata, rd;
    int n_errors = 0;
    int check_count = 0;
    int cyc;

    always #5 core_clk_in = ~core_clk_in;

    // One delay unit every four cycles, so intervals are easy to count.
    always @(negedge core_clk_in) begin
        tick_phase <= tick_phase + 2'h1;
        unit_tick <= (tick_phase == 2'h3);
    end

    input_ov_fault_response dut_u (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
        .cmd_write_in(cmd_write), .cmd_read_in(cmd_read), .cmd_code_in(cmd_code),
        .cmd_wdata_in(cmd_wdata), .cmd_rdata_out(cmd_rdata), .cmd_ack_out(cmd_ack),
        .cmd_nack_out(cmd_nack), .clear_faults_in(clr_faults), .clear_warn_bit_in(clr_bit),
        .fault_reset_pin_in(rst_pin), .ctrl_pin_in(ctrl_pin), .operation_on_in(op_on),
        .vin_ov_warn_in(vin_ov_warn), .unit_tick_in(unit_tick), .power_enable_out(power),
        .warn_latched_out(latched), .retry_count_out(tries), .restarting_out(restarting));

    pmbus_host_model host_u (.core_clk_in(core_clk_in), .cmd_ack_in(cmd_ack), .cmd_nack_in(cmd_nack),
        .cmd_rdata_in(cmd_rdata), .cmd_write_out(cmd_write), .cmd_read_out(cmd_read),
        .cmd_code_out(cmd_code), .cmd_wdata_out(cmd_wdata), .clear_faults_out(clr_faults),
        .clear_warn_bit_out(clr_bit), .fault_reset_pin_out(rst_pin), .ctrl_pin_out(ctrl_pin),
        .operation_on_out(op_on));

    // ==========================================================
    // Helpers
    task automatic cmp_bit(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_bit

    task automatic cmp_vec(input string what, input logic [STORE_W-1:0] exp, input logic [STORE_W-1:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_vec

    task automatic cycles(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask : cycles

    task automatic wr(input logic [7:0] code, input logic [STORE_W-1:0] d);
        host_u.access(1'b1, code, d, rd, ack, nack);
    endtask : wr

    task automatic rd_cmp(input string what, input logic [7:0] code, input logic [STORE_W-1:0] exp);
        host_u.access(1'b0, code, '0, rd, ack, nack);
        cmp_bit(what, 1'b1, ack);
        cmp_vec(what, exp, rd);
    endtask : rd_cmp

    task automatic wait_power(input logic exp);
        cyc = 0;
        while (power !== exp && cyc < 20) begin
            @(negedge core_clk_in);
            cyc++;
        end
        cmp_bit("power", exp, power);
    endtask : wait_power

    task automatic wait_change();
        logic [2:0] prev;
        prev = tries;
        cyc = 0;
        while (tries === prev && cyc < 2000) begin
            @(negedge core_clk_in);
            cyc++;
        end
    endtask : wait_change

    task automatic report_and_stop();
        if (n_errors == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    // ==========================================================
    // Tests
    initial begin
        cycles(20);
        sys_rst_in = 1'b0;
        cycles(6);
        cmp_bit("power up", 1'b1, power);
        rd_cmp("action reset", CODE_WARN_ACTION, '0);
        rd_cmp("store reset", CODE_USER_STORE, '0);
        host_u.write_read(CODE_WARN_ACTION, 128'h33, rd, ack);
        cmp_bit("action b2b ack", 1'b1, ack);
        cmp_vec("action b2b", 128'h33, rd);
        wr(CODE_WARN_ACTION, {{120{1'b1}}, 8'h8a});
        rd_cmp("action", CODE_WARN_ACTION, 128'h8a);
        wr(CODE_USER_STORE, "user data bytes!");
        rd_cmp("store", CODE_USER_STORE, "user data bytes!");
        host_u.write_read(CODE_USER_STORE, "back to back wr.", rd, ack);
        cmp_bit("store b2b ack", 1'b1, ack);
        cmp_vec("store b2b", "back to back wr.", rd);
        wr(8'hc5, '1);
        cmp_bit("unknown nack", 1'b1, nack);
        rd_cmp("action kept", CODE_WARN_ACTION, 128'h8a);
        wr(CODE_WARN_ACTION, 128'h00);
        vin_ov_warn = 1'b1;
        cycles(60);
        cmp_bit("ignore power", 1'b1, power);
        cmp_bit("ignore restart", 1'b0, restarting);
        vin_ov_warn = 1'b0;
        host_u.clear_fault(1);
        wr(CODE_WARN_ACTION, 128'h42);
        vin_ov_warn = 1'b1;
        cycles(10);
        cmp_bit("grace power", 1'b1, power);
        cycles(30);
        cmp_bit("grace expired", 1'b0, power);
        vin_ov_warn = 1'b0;
        host_u.clear_fault(1);
        wait_power(1'b1);
        wr(CODE_WARN_ACTION, 128'hc0);
        for (int k = 0; k < 6; k++) begin
            vin_ov_warn = 1'b1;
            cycles(6);
            cmp_bit("latch off", 1'b0, power);
            vin_ov_warn = 1'b0;
            cycles(20);
            cmp_bit("latch held", 1'b0, power);
            cmp_bit("status set", 1'b1, latched);
            host_u.clear_fault(k);
            wait_power(1'b1);
            cmp_bit("status clear", 1'b0, latched);
        end
        // The continuous case is ended here by taking the control pin low.
        for (int r = 0; r < 8; r++) begin
            wr(CODE_WARN_ACTION, {120'h0, 2'b10, 3'(r), 3'h1});
            vin_ov_warn = 1'b1;
            cycles(6);
            cmp_bit("retry off", 1'b0, power);
            cycles(300);
            cmp_bit("retry running", r == 7, restarting);
            if (r < 7) begin
                cmp_vec("attempts", r, tries);
                cmp_bit("final off", 1'b0, power);
            end
            vin_ov_warn = 1'b0;
            host_u.clear_fault((r == 7) ? 3 : 1);
            wait_power(1'b1);
            cmp_vec("attempts cleared", 0, tries);
        end
        for (int d = 1; d < 4; d++) begin
            wr(CODE_WARN_ACTION, {120'h0, 2'b10, RETRY_FOREVER, 3'(d)});
            vin_ov_warn = 1'b1;
            wait_change();
            wait_change();
            wait_change();
            cmp_vec("attempt spacing", (1 << d) * 4, cyc);
            vin_ov_warn = 1'b0;
            host_u.clear_fault(3);
            wait_power(1'b1);
        end
        report_and_stop();
    end

    // The tests need about three thousand cycles; this allows over six times that.
    initial begin
        #200000;
        n_errors++;
        report_and_stop();
    end

endmodule : tb_input_ov_fault_response
